// file: verilog/xcm_pkg.sv
package xcm_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] XCM_OFF_INV = 8'h04;
  localparam logic [7:0] XCM_OFF_STAT = 8'h08;
  localparam logic [7:0] XCM_OFF_HIT = 8'h0c;
  localparam logic [7:0] XCM_OFF_ACC = 8'h10;
  localparam logic [7:0] XCM_OFF_PADDR = 8'h14;
  localparam logic [7:0] XCM_OFF_PCNT = 8'h18;
  localparam logic [7:0] XCM_OFF_PDATA = 8'h1c;
  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int XCM_INV_BIT = 0;
  localparam int XCM_STAT_DONE_BIT = 0;
  localparam int XCM_STAT_EMPTY_BIT = 1;
  localparam int XCM_STAT_FULL_BIT = 2;
  localparam int XCM_CNT_W = 22;
  localparam int XCM_ADDR_LSB = 2;
  localparam logic [31:0] XCM_ZERO32 = 32'h0000_0000;
  localparam logic [31:0] XCM_MAX32 = 32'hffff_ffff;
  localparam logic [29:0] XCM_WADDR_RST = 30'h0000_0000;
  localparam logic [21:0] XCM_CNT_RST = 22'h00_0000;
  // ************************************************************
  // timing
  // ************************************************************
  localparam logic [2:0] XCM_COOLDOWN = 3'h7;
  // ************************************************************
  // ahb-lite encodings
  // ************************************************************
  localparam logic [1:0] XCM_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] XCM_HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {
    XCM_INV_IDLE = 2'b00,
    XCM_INV_RUN = 2'b01
  } xcm_inv_state_type;
endpackage

// file: verilog/xcm_maint_prefetch.sv
`timescale 1ns/1ps
// Notes on behaviour
// - trigger bit clears tags, keeps data storage
// - trigger register read stalls until invalidation done
// - status bit0 low while invalidation runs
// - invalidation starts automatically after reset
// - buffer two entries; bit2 means full
// - bit1 means buffer empty; set after reset
// - hit counter saturates; any write clears
// - access counter saturates; any write clears
// - address register advances one word per read
// - nonzero count starts idle-cycle linear prefetch
// - count decrements per word; stops at zero
// - writing zero aborts, drops in-flight read
// - data register read pops oldest word
// - auxiliary port also pops the buffer
// - prefetch yields; waits seven idle cycles after miss
// - dma request raised whenever buffer holds data
module xcm_maint_prefetch
  import xcm_pkg::*;
#(
  parameter int TAG_ENTRIES = 64,
  parameter int TAG_IDX_W = 6
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // ahb-lite register slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // auxiliary buffer read port, zero wait
  input wire logic aux_rd_i,
  output logic [31:0] aux_rdata_o,
  // flash window activity from the cache
  input wire logic win_access_i,
  input wire logic win_hit_i,
  input wire logic win_miss_i,
  input wire logic flash_busy_i,
  // flash read port for prefetch
  output logic pf_req_o,
  output logic [31:0] pf_addr_o,
  input wire logic pf_gnt_i,
  input wire logic pf_rvalid_i,
  input wire logic [31:0] pf_rdata_i,
  // tag store clear port
  output logic tag_clr_o,
  output logic [TAG_IDX_W-1:0] tag_clr_idx_o,
  // dma request
  output logic dreq_o
);
  // ************************************************************
  // bus address phase capture
  // ************************************************************
  logic dp_ff;
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic inv_busy;
  xcm_inv_state_type inv_st_ff;
  logic [TAG_IDX_W-1:0] inv_idx_ff;
  logic inv_req_ff;
  logic [31:0] hit_ff;
  logic [31:0] acc_ff;
  logic [29:0] waddr_ff;
  logic [XCM_CNT_W-1:0] cnt_ff;
  logic [2:0] cool_ff;
  logic infl_ff;
  logic [31:0] buf_ff [2];
  logic [1:0] lvl_ff;
  logic rd_ptr_ff;
  logic addr_ph;
  logic wr_stb;
  logic rd_stb;
  logic pop_bus;
  logic pop;
  logic push;
  logic issue;
  logic [31:0] rdata;

  assign addr_ph = hsel_i && hready_i && (htrans_i == XCM_HTRANS_NONSEQ || htrans_i == XCM_HTRANS_SEQ);
  assign inv_busy = (inv_st_ff == XCM_INV_RUN) || inv_req_ff;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dp_ff <= 1'b0;
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else if (hready_ff) begin
      dp_ff <= addr_ph;
      dp_wr_ff <= hwrite_i;
      dp_addr_ff <= haddr_i[7:0];
    end
  end

  // trigger register read holds the bus while invalidation runs
  logic stall;
  logic abort_wr;
  logic trig_wr;
  logic inv_busy_nxt;
  logic inv_rd_wait;
  assign stall = dp_ff && !dp_wr_ff && dp_addr_ff == XCM_OFF_INV && inv_busy;
  // write data arrives in the data phase; act on the last data-phase cycle
  assign wr_stb = dp_ff && dp_wr_ff && hready_ff;
  assign rd_stb = dp_ff && !dp_wr_ff && !stall;
  assign trig_wr = wr_stb && dp_addr_ff == XCM_OFF_INV && hwdata_i[XCM_INV_BIT];
  assign abort_wr = wr_stb && dp_addr_ff == XCM_OFF_PCNT && hwdata_i[XCM_CNT_W-1:0] == XCM_CNT_RST;
  assign inv_busy_nxt = inv_req_ff || trig_wr
                        || (inv_st_ff == XCM_INV_RUN && inv_idx_ff != TAG_IDX_W'(TAG_ENTRIES - 1));
  assign inv_rd_wait = (addr_ph && hready_ff && !hwrite_i && haddr_i[7:0] == XCM_OFF_INV)
                       || (dp_ff && !dp_wr_ff && dp_addr_ff == XCM_OFF_INV && !hready_ff);

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hready_ff <= 1'b1;
    end else begin
      // look one cycle ahead so a sweep still pending cannot slip past a stalled read
      hready_ff <= !(inv_rd_wait && inv_busy_nxt);
    end
  end

  // ************************************************************
  // tag invalidation
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      inv_req_ff <= 1'b1;
    end else if (wr_stb && dp_addr_ff == XCM_OFF_INV && hwdata_i[XCM_INV_BIT]) begin
      inv_req_ff <= 1'b1;
    end else if (inv_st_ff == XCM_INV_IDLE) begin
      inv_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      inv_st_ff <= XCM_INV_IDLE;
      inv_idx_ff <= '0;
    end else begin
      case (inv_st_ff)
        XCM_INV_IDLE: begin
          if (inv_req_ff) begin
            inv_st_ff <= XCM_INV_RUN;
            inv_idx_ff <= '0;
          end
        end
        XCM_INV_RUN: begin
          // only tags are walked; data storage is never touched
          if (inv_idx_ff == TAG_IDX_W'(TAG_ENTRIES - 1)) begin
            inv_st_ff <= XCM_INV_IDLE;
          end
          inv_idx_ff <= inv_idx_ff + 1'b1;
        end
        default: inv_st_ff <= XCM_INV_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tag_clr_o <= 1'b0;
      tag_clr_idx_o <= '0;
    end else begin
      tag_clr_o <= (inv_st_ff == XCM_INV_RUN);
      tag_clr_idx_o <= inv_idx_ff;
    end
  end

  // ************************************************************
  // performance counters
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hit_ff <= XCM_ZERO32;
    end else if (wr_stb && dp_addr_ff == XCM_OFF_HIT) begin
      hit_ff <= XCM_ZERO32;
    end else if (win_hit_i && hit_ff != XCM_MAX32) begin
      hit_ff <= hit_ff + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      acc_ff <= XCM_ZERO32;
    end else if (wr_stb && dp_addr_ff == XCM_OFF_ACC) begin
      acc_ff <= XCM_ZERO32;
    end else if (win_access_i && acc_ff != XCM_MAX32) begin
      acc_ff <= acc_ff + 32'h1;
    end
  end

  // ************************************************************
  // prefetch engine
  // ************************************************************
  // reads only when flash idle, cooldown expired, count live and room left
  assign issue = cnt_ff != XCM_CNT_RST && !infl_ff && !flash_busy_i && !win_access_i
                 && cool_ff == 3'h0 && (lvl_ff + {1'b0, infl_ff}) < 2'h2;
  assign pop_bus = rd_stb && dp_addr_ff == XCM_OFF_PDATA && lvl_ff != 2'h0;
  assign pop = pop_bus || (aux_rd_i && lvl_ff != 2'h0);
  assign push = infl_ff && pf_rvalid_i && !abort_wr;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cool_ff <= 3'h0;
    end else if (win_miss_i) begin
      cool_ff <= XCM_COOLDOWN;
    end else if (cool_ff != 3'h0 && !win_access_i) begin
      cool_ff <= cool_ff - 3'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= XCM_CNT_RST;
    end else if (wr_stb && dp_addr_ff == XCM_OFF_PCNT) begin
      cnt_ff <= hwdata_i[XCM_CNT_W-1:0];
    end else if (pf_req_o && pf_gnt_i) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      waddr_ff <= XCM_WADDR_RST;
    end else if (wr_stb && dp_addr_ff == XCM_OFF_PADDR) begin
      waddr_ff <= hwdata_i[31:XCM_ADDR_LSB];
    end else if (pf_req_o && pf_gnt_i) begin
      waddr_ff <= waddr_ff + 30'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pf_req_o <= 1'b0;
      infl_ff <= 1'b0;
    end else if (abort_wr) begin
      pf_req_o <= 1'b0;
      infl_ff <= 1'b0;
    end else if (pf_req_o) begin
      // a request yields to any window access that turns up meanwhile
      pf_req_o <= !pf_gnt_i && !win_access_i;
      infl_ff <= pf_gnt_i;
    end else begin
      pf_req_o <= issue && cnt_ff != XCM_CNT_RST;
      if (pf_rvalid_i) begin
        infl_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pf_addr_o <= XCM_ZERO32;
    end else begin
      pf_addr_o <= {waddr_ff, 2'b00};
    end
  end

  // ************************************************************
  // two-entry prefetch buffer
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      lvl_ff <= 2'h0;
      rd_ptr_ff <= 1'b0;
    end else begin
      lvl_ff <= lvl_ff + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        rd_ptr_ff <= !rd_ptr_ff;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      buf_ff[rd_ptr_ff ^ lvl_ff[0]] <= pf_rdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dreq_o <= 1'b0;
      aux_rdata_o <= XCM_ZERO32;
    end else begin
      dreq_o <= (lvl_ff + {1'b0, push} - {1'b0, pop}) != 2'h0;
      aux_rdata_o <= (lvl_ff != 2'h0) ? buf_ff[rd_ptr_ff] : XCM_ZERO32;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rdata = XCM_ZERO32;
    if (haddr_i[7:0] == XCM_OFF_STAT) begin
      rdata[XCM_STAT_DONE_BIT] = !inv_busy;
      rdata[XCM_STAT_EMPTY_BIT] = (lvl_ff == 2'h0);
      rdata[XCM_STAT_FULL_BIT] = (lvl_ff == 2'h2);
    end else if (haddr_i[7:0] == XCM_OFF_HIT) begin
      rdata = hit_ff;
    end else if (haddr_i[7:0] == XCM_OFF_ACC) begin
      rdata = acc_ff;
    end else if (haddr_i[7:0] == XCM_OFF_PADDR) begin
      rdata = {waddr_ff, 2'b00};
    end else if (haddr_i[7:0] == XCM_OFF_PCNT) begin
      rdata = {10'h000, cnt_ff};
    end else if (haddr_i[7:0] == XCM_OFF_PDATA) begin
      rdata = (lvl_ff != 2'h0) ? buf_ff[rd_ptr_ff] : XCM_ZERO32;
    end
  end

  // data is captured at the address phase; the trigger register reads zero
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hrdata_ff <= XCM_ZERO32;
    end else if (addr_ph && hready_ff && !hwrite_i) begin
      hrdata_ff <= rdata;
    end
  end

  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o = 1'b0;
endmodule

// file: dv/xcm_maint_prefetch_chk.sv
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module xcm_maint_prefetch_chk
  import xcm_pkg::*;
#(parameter int TAG_ENTRIES = 64, parameter int TAG_IDX_W = 6) (
  input wire logic mclk_i, rst_b_i, hsel_i, hready_i, hwrite_i, hreadyout_o,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i, hwdata_i, pf_addr_o,
  input wire logic win_miss_i, pf_req_o, pf_gnt_i, pf_rvalid_i, tag_clr_o, dreq_o,
  input wire logic [TAG_IDX_W-1:0] tag_clr_idx_o
);
  logic cnt_wr_ff;
  logic [3:0] since_miss_ff;
  int clr_run_ff;
  // miss distance saturates so a long idle stretch cannot wrap back under seven
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_wr_ff <= 1'b0;
      since_miss_ff <= 4'h0;
      clr_run_ff <= 0;
    end else begin
      cnt_wr_ff <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == XCM_OFF_PCNT;
      since_miss_ff <= win_miss_i ? 4'h0 : since_miss_ff + {3'h0, since_miss_ff != 4'hf};
      clr_run_ff <= tag_clr_o ? clr_run_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  AST_INV_AFTER_RST: assert property ($rose(rst_b_i) |-> ##[1:3] tag_clr_o)
    else $error("no invalidation after reset");
  AST_INV_FIRST: assert property ($rose(tag_clr_o) |-> tag_clr_idx_o == '0)
    else $error("sweep not from entry zero");
  AST_INV_STEP: assert property (tag_clr_o && $past(tag_clr_o) |->
    tag_clr_idx_o == $past(tag_clr_idx_o) + 1'b1) else $error("sweep index skipped");
  AST_INV_LEN: assert property ($fell(tag_clr_o) |-> clr_run_ff == TAG_ENTRIES)
    else $error("sweep length wrong");
  AST_STALL_CAUSE: assert property (!hreadyout_o |-> tag_clr_o || $past(tag_clr_o) || $past(tag_clr_o, 2))
    else $error("wait state outside invalidation");
  AST_STALL_END: assert property ($fell(hreadyout_o) |-> ##[1:300] hreadyout_o)
    else $error("stall never ends");
  AST_DREQ_SRC: assert property ($rose(dreq_o) |-> $past(pf_rvalid_i) || $past(pf_rvalid_i, 2))
    else $error("dreq w/o data");
  // the address port is registered, so the step shows two cycles after the grant
  AST_ADDR_STEP: assert property (pf_req_o && pf_gnt_i |-> ##2 pf_addr_o == $past(pf_addr_o, 2) + 32'h4)
    else $error("addr step");
  AST_COOLDOWN: assert property ($rose(pf_req_o) |-> since_miss_ff >= 4'h7)
    else $error("prefetch too soon");
  AST_ABORT: assert property (cnt_wr_ff && hwdata_i[21:0] == XCM_CNT_RST |-> ##2 !pf_req_o)
    else $error("abort ignored");
  cover property (!hreadyout_o);
  cover property ($rose(dreq_o));
  cover property (pf_req_o && pf_gnt_i);
endmodule
bind xcm_maint_prefetch xcm_maint_prefetch_chk #(.TAG_ENTRIES(TAG_ENTRIES), .TAG_IDX_W(TAG_IDX_W)) u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .hready_i(hready_i), .hwrite_i(hwrite_i),
  .hreadyout_o(hreadyout_o), .htrans_i(htrans_i), .haddr_i(haddr_i), .hwdata_i(hwdata_i),
  .pf_addr_o(pf_addr_o), .win_miss_i(win_miss_i), .pf_req_o(pf_req_o), .pf_gnt_i(pf_gnt_i),
  .pf_rvalid_i(pf_rvalid_i), .tag_clr_o(tag_clr_o), .dreq_o(dreq_o), .tag_clr_idx_o(tag_clr_idx_o));

// file: dv/xcm_flash_model.sv
`timescale 1ns/1ps
// ****************
// flash read port model, one read outstanding
// ****************
module xcm_flash_model (
  input wire logic mclk_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic slow_i,
  output logic gnt_o = 1'b0,
  output logic rvalid_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0
);
  int wait_cnt = 0;
  logic [31:0] addr_q = 32'h0;
  always @(posedge mclk_i) begin
    gnt_o <= 1'b0;
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o;  // data line is not held outside a return
    if (gnt_o) begin
      // a grant the engine already withdrew is simply lost
      if (req_i) begin
        addr_q <= addr_i;
        wait_cnt <= slow_i ? 8 : 2;
      end
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1) begin
        rvalid_o <= 1'b1;
        rdata_o <= addr_q ^ 32'ha5c3_0000;
      end
    end else if (req_i) begin
      gnt_o <= 1'b1;
    end
  end
endmodule

// file: dv/xcm_maint_prefetch_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module xcm_maint_prefetch_tb;
  import xcm_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, hsel_i = 0, hwrite_i = 0, aux_rd_i = 0, act = 0, slow_sel = 0, slow = 0;
  logic win_access_i = 0, win_hit_i = 0, win_miss_i = 0, flash_busy_i = 0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd, r, hrdata_o, aux_rdata_o, pf_addr_o, pf_rdata_i;
  logic hreadyout_o, hresp_o, pf_req_o, pf_gnt_i, pf_rvalid_i, tag_clr_o, dreq_o;
  logic [2:0] tag_clr_idx_o;
  logic [7:0] offs[6] = '{XCM_OFF_HIT, XCM_OFF_ACC, XCM_OFF_PADDR, XCM_OFF_PCNT, XCM_OFF_PDATA, 8'h20};
  int failures = 0, num_checks = 0, cyc = 0, hits = 0, accs = 0, clr_n = 0;
  integer seed = 32'h76883bc1;
  logic [31:0] exp_q[$];
  xcm_maint_prefetch #(.TAG_ENTRIES(8), .TAG_IDX_W(3)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .aux_rd_i(aux_rd_i), .aux_rdata_o(aux_rdata_o), .win_access_i(win_access_i),
    .win_hit_i(win_hit_i), .win_miss_i(win_miss_i), .flash_busy_i(flash_busy_i), .pf_req_o(pf_req_o),
    .pf_addr_o(pf_addr_o), .pf_gnt_i(pf_gnt_i), .pf_rvalid_i(pf_rvalid_i), .pf_rdata_i(pf_rdata_i),
    .tag_clr_o(tag_clr_o), .tag_clr_idx_o(tag_clr_idx_o), .dreq_o(dreq_o));
  xcm_flash_model u_flash (.mclk_i(mclk_i), .req_i(pf_req_o), .addr_i(pf_addr_o), .slow_i(slow),
    .gnt_o(pf_gnt_i), .rvalid_o(pf_rvalid_i), .rdata_o(pf_rdata_i));
  always #20 mclk_i = ~mclk_i;
  // ****************
  // window traffic and its counter model
  // ****************
  always @(posedge mclk_i) begin
    r = $random(seed);
    cyc <= cyc + 1;
    clr_n <= clr_n + int'(tag_clr_o === 1'b1);
    win_access_i <= act & (r[1:0] == 2'h0);
    win_hit_i <= act & (r[1:0] == 2'h0) & r[2];
    win_miss_i <= act & (r[1:0] == 2'h0) & ~r[2];
    flash_busy_i <= act & r[4] & r[5];
    slow <= slow_sel | r[3];
    accs <= accs + int'(act & (r[1:0] == 2'h0));
    hits <= hits + int'(act & (r[1:0] == 2'h0) & r[2]);
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= XCM_HTRANS_NONSEQ;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    `CHK("hresp", 1'b0, hresp_o)
  endtask
  task automatic run(input logic [31:0] a, input int n);
    bus(1'b1, XCM_OFF_PADDR, a);
    bus(1'b1, XCM_OFF_PCNT, n);
    for (int i = 0; i < n; i++) exp_q.push_back((a + 4 * i) ^ 32'ha5c3_0000);
  endtask
  // alternate pops between the register port and the zero-wait port
  task automatic pop(input int aux);
    logic [31:0] e;
    e = exp_q.pop_front();
    while (dreq_o !== 1'b1) @(posedge mclk_i);
    if (aux) begin
      aux_rd_i <= 1'b1;
      @(posedge mclk_i);
      rd = aux_rdata_o;
      aux_rd_i <= 1'b0;
      @(posedge mclk_i);
    end else bus(1'b0, XCM_OFF_PDATA, 32'h0);
    @(posedge mclk_i);
    `CHK("fifo", e, rd)
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    bus(1'b0, XCM_OFF_STAT, 32'h0);
    `CHK("stat", 32'h2, rd)
    bus(1'b0, XCM_OFF_INV, 32'h0);
    // the clear counter takes its last sample at the completing edge
    @(posedge mclk_i);
    `CHK("clr", 8, clr_n)
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      `CHK("reset", 32'h0, rd)
    end
    bus(1'b1, XCM_OFF_INV, 32'h1);
    @(posedge mclk_i iff tag_clr_o);
    bus(1'b0, XCM_OFF_INV, 32'h0);
    @(posedge mclk_i);
    `CHK("clr", 16, clr_n)
    act <= 1'b1;
    run(32'h100, 5);
    do bus(1'b0, XCM_OFF_STAT, 32'h0); while (rd[2] !== 1'b1);
    `CHK("full", 32'h5, rd)
    repeat (30) @(posedge mclk_i);
    bus(1'b0, XCM_OFF_PCNT, 32'h0);
    `CHK("count", 32'h3, rd)
    bus(1'b0, XCM_OFF_PADDR, 32'h0);
    `CHK("addr", 32'h108, rd)
    for (int i = 0; i < 5; i++) pop(i % 2);
    act <= 1'b0;
    repeat (4) @(posedge mclk_i);
    bus(1'b0, XCM_OFF_HIT, 32'h0);
    `CHK("hits", hits, rd)
    bus(1'b0, XCM_OFF_ACC, 32'h0);
    `CHK("accs", accs, rd)
    bus(1'b1, XCM_OFF_HIT, r);
    bus(1'b1, XCM_OFF_ACC, ~r);
    bus(1'b0, XCM_OFF_ACC, 32'h0);
    `CHK("acc clear", 32'h0, rd)
    bus(1'b0, XCM_OFF_HIT, 32'h0);
    `CHK("hit clear", 32'h0, rd)
    bus(1'b0, XCM_OFF_PADDR, 32'h0);
    `CHK("addr", 32'h114, rd)
    slow_sel <= 1'b1;
    run(32'h200, 10);
    @(posedge mclk_i iff (pf_gnt_i && pf_req_o));
    bus(1'b1, XCM_OFF_PCNT, 32'h0);
    bus(1'b0, XCM_OFF_STAT, 32'h0);
    `CHK("abort", 32'h3, rd)
    repeat (20) @(posedge mclk_i);
    bus(1'b0, XCM_OFF_STAT, 32'h0);
    `CHK("abort", 32'h3, rd)
    repeat (2) bus(1'b0, XCM_OFF_PDATA, 32'h0);
    exp_q.delete();
    slow_sel <= 1'b0;
    run(32'h300, 2);
    pop(0);
    pop(1);
    bus(1'b0, XCM_OFF_STAT, 32'h0);
    `CHK("stat", 32'h3, rd)
    finish_test();
  end
endmodule
